// ==== core/timer2_core.sv ====
// Eight-bit timer with two compare channels behind a classic Wishbone slave.
// Assumes a single 250 MHz clock as the timer source and same-clock vector acknowledges.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "timer2_regs.svh"

module timer2_core
  import timer2_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Vector execution acknowledges
  input wire logic VECTOR_DONE_A,
  input wire logic VECTOR_DONE_B,
  input wire logic VECTOR_DONE_OVF,
  // Compare output pins
  output logic COMPARE_OUT_A,
  output logic COMPARE_OUT_A_EN,
  output logic COMPARE_OUT_B,
  output logic COMPARE_OUT_B_EN
);

  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] ctrl_a_r;
  logic [3:0] ctrl_b_r;
  logic [7:0] count_r;
  logic [7:0] cmp_a_r;
  logic [7:0] cmp_b_r;
  logic [7:0] cmp_a_act_r;
  logic [7:0] cmp_b_act_r;
  logic [2:0] flags_r;
  logic down_r;
  logic blk_r;
  logic [9:0] pre_r;
  logic out_a_r;
  logic out_b_r;
  logic oe_a_r;
  logic oe_b_r;

  logic req;
  logic wr;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_flags;
  wave_mode_t mode;
  out_action_t act_a;
  out_action_t act_b;
  logic [2:0] cs;
  logic pwm;
  logic fast;
  logic phase;
  logic tick;
  logic [9:0] pre_mask;
  logic [7:0] cmp_a_eff;
  logic [7:0] cmp_b_eff;
  logic [7:0] top;
  logic at_top;
  logic match_a_ev;
  logic match_b_ev;
  logic ovf_ev;
  logic force_a;
  logic force_b;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [7:0] count_nxt;
  logic down_nxt;
  logic out_a_nxt;
  logic out_b_nxt;
  logic [7:0] rd_byte;

  // Bus decode; a write lands on the edge that sees the acknowledge.
  assign req = WB_CYC_I & WB_STB_I;
  assign wr = req & WB_WE_I & ack_r & WB_SEL_I[0];
  assign wr_ctrl_a = wr & (WB_ADR_I == `OFS_WAVEFORM_CONTROL_A);
  assign wr_ctrl_b = wr & (WB_ADR_I == `OFS_WAVEFORM_CONTROL_B);
  assign wr_count = wr & (WB_ADR_I == `OFS_COUNT_VALUE);
  assign wr_flags = wr & (WB_ADR_I == `OFS_FLAGS);

  assign mode = wave_mode_t'({ctrl_b_r[`BIT_MODE_HIGH], ctrl_a_r[1:0]});
  assign act_a = ctrl_a_r[7:6];
  assign act_b = ctrl_a_r[5:4];
  assign cs = ctrl_b_r[2:0];
  assign fast = (mode == MODE_FAST_FF) | (mode == MODE_FAST_OCR);
  assign phase = (mode == MODE_PHASE_FF) | (mode == MODE_PHASE_OCR);
  assign pwm = fast | phase;

  // Prescaler; the divider restarts while stopped so every division starts aligned.
  always_comb begin
    case (cs)
      3'h2: pre_mask = `PRE_MASK_8;
      3'h3: pre_mask = `PRE_MASK_32;
      3'h4: pre_mask = `PRE_MASK_64;
      3'h5: pre_mask = `PRE_MASK_128;
      3'h6: pre_mask = `PRE_MASK_256;
      3'h7: pre_mask = `PRE_MASK_1024;
      default: pre_mask = 10'h000;
    endcase
  end
  assign tick = (cs != 3'h0) & ((pre_r & pre_mask) == pre_mask);

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N || cs == 3'h0) begin
      pre_r <= 10'h000;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // Compare values act at once outside PWM and wait for top inside it.
  assign cmp_a_eff = pwm ? cmp_a_act_r : cmp_a_r;
  assign cmp_b_eff = pwm ? cmp_b_act_r : cmp_b_r;
  assign top = (mode == MODE_CTC || mode == MODE_PHASE_OCR || mode == MODE_FAST_OCR) ?
               cmp_a_eff : `COUNT_MAX;
  assign at_top = tick & (count_r == top);
  assign match_a_ev = tick & ~blk_r & (count_r == cmp_a_eff);
  assign match_b_ev = tick & ~blk_r & (count_r == cmp_b_eff);
  assign force_a = wr_ctrl_b & WB_DAT_I[`BIT_FORCE_A] & ~pwm;
  assign force_b = wr_ctrl_b & WB_DAT_I[`BIT_FORCE_B] & ~pwm;

  always_comb begin
    if (phase) begin
      ovf_ev = tick & down_r & (count_r == `COUNT_BOTTOM);
    end else if (mode == MODE_FAST_OCR) begin
      ovf_ev = at_top;
    end else begin
      ovf_ev = tick & (count_r == `COUNT_MAX);
    end
  end

  // Count sequence; a software write beats a tick in the same cycle.
  always_comb begin
    count_nxt = count_r;
    down_nxt = down_r;
    if (wr_count) begin
      count_nxt = WB_DAT_I[7:0];
    end else if (tick) begin
      if (phase) begin
        if (!down_r && count_r == top) begin
          down_nxt = 1'b1;
          count_nxt = count_r - 8'h01;
        end else if (down_r && count_r == `COUNT_BOTTOM) begin
          down_nxt = 1'b0;
          count_nxt = count_r + 8'h01;
        end else begin
          count_nxt = down_r ? count_r - 8'h01 : count_r + 8'h01;
        end
      end else if (count_r == top) begin
        count_nxt = `COUNT_BOTTOM;
      end else begin
        count_nxt = count_r + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      count_r <= `RESET_BYTE;
      down_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      down_r <= phase ? down_nxt : 1'b0;
    end
  end

  // A counter write hides the match of the next tick only.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      blk_r <= 1'b0;
    end else if (wr_count) begin
      blk_r <= 1'b1;
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  // Output action for one channel in the current mode.
  function automatic logic out_next(input logic cur, input out_action_t act, input logic is_a,
                                    input wave_mode_t m, input logic match, input logic top_ev,
                                    input logic down, input logic cmp_top, input logic frc);
    logic r;
    r = cur;
    case (m)
      MODE_FAST_FF, MODE_FAST_OCR: begin
        if (act == 2'b01) begin
          if (is_a && m == MODE_FAST_OCR && match) r = ~cur;
        end else if (act[1]) begin
          if (match && !cmp_top) r = act[0];
          if (top_ev) r = ~act[0];
        end
      end
      MODE_PHASE_FF, MODE_PHASE_OCR: begin
        if (act == 2'b01) begin
          if (is_a && m == MODE_PHASE_OCR && match) r = ~cur;
        end else if (act[1]) begin
          if (match && !cmp_top) r = down ? ~act[0] : act[0];
          if (top_ev && cmp_top) r = ~act[0];
        end
      end
      default: begin
        if (match || frc) begin
          case (act)
            2'b01: r = ~cur;
            2'b10: r = 1'b0;
            2'b11: r = 1'b1;
            default: r = cur;
          endcase
        end
      end
    endcase
    return r;
  endfunction

  assign out_a_nxt = out_next(out_a_r, act_a, 1'b1, mode, match_a_ev, at_top, down_r,
                              cmp_a_eff == top, force_a);
  assign out_b_nxt = out_next(out_b_r, act_b, 1'b0, mode, match_b_ev, at_top, down_r,
                              cmp_b_eff == top, force_b);

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
      oe_a_r <= 1'b0;
      oe_b_r <= 1'b0;
    end else begin
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
      oe_a_r <= |act_a;
      oe_b_r <= |act_b;
    end
  end

  // Software registers.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ctrl_a_r <= `RESET_BYTE;
      ctrl_b_r <= 4'h0;
      cmp_a_r <= `RESET_BYTE;
      cmp_b_r <= `RESET_BYTE;
    end else begin
      if (wr_ctrl_a) ctrl_a_r <= WB_DAT_I[7:0] & `CTRL_A_RW_MASK;
      if (wr_ctrl_b) ctrl_b_r <= WB_DAT_I[3:0];
      if (wr & (WB_ADR_I == `OFS_COMPARE_VALUE_A)) cmp_a_r <= WB_DAT_I[7:0];
      if (wr & (WB_ADR_I == `OFS_COMPARE_VALUE_B)) cmp_b_r <= WB_DAT_I[7:0];
    end
  end

  // Buffered compare values reload at top in the PWM modes.
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      cmp_a_act_r <= `RESET_BYTE;
      cmp_b_act_r <= `RESET_BYTE;
    end else if (!pwm || at_top) begin
      cmp_a_act_r <= cmp_a_r;
      cmp_b_act_r <= cmp_b_r;
    end
  end

  // Flags: a setting event wins over a clear in the same cycle.
  assign flag_set = {match_b_ev, match_a_ev, ovf_ev};
  assign flag_clr = {VECTOR_DONE_B, VECTOR_DONE_A, VECTOR_DONE_OVF} |
                    (wr_flags ? WB_DAT_I[2:0] : 3'h0);
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      flags_r <= 3'h0;
    end else begin
      flags_r <= flag_set | (flags_r & ~flag_clr);
    end
  end

  // Read path; unmapped addresses read zero and are acknowledged.
  always_comb begin
    case (WB_ADR_I)
      `OFS_WAVEFORM_CONTROL_A: rd_byte = ctrl_a_r & `CTRL_A_RW_MASK;
      `OFS_WAVEFORM_CONTROL_B: rd_byte = {4'h0, ctrl_b_r};
      `OFS_COUNT_VALUE: rd_byte = count_r;
      `OFS_COMPARE_VALUE_A: rd_byte = cmp_a_r;
      `OFS_COMPARE_VALUE_B: rd_byte = cmp_b_r;
      `OFS_FLAGS: rd_byte = {5'h00, flags_r};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) dat_r <= {24'h00_0000, rd_byte};
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
  assign COMPARE_OUT_A = out_a_r;
  assign COMPARE_OUT_B = out_b_r;
  assign COMPARE_OUT_A_EN = oe_a_r;
  assign COMPARE_OUT_B_EN = oe_b_r;

  property p_enable_follows_action;
    @(posedge CLK_SYS) disable iff (!RESET_N) ##1 (COMPARE_OUT_B_EN == |$past(act_b));
  endproperty
  a_enable_follows_action: assert property (p_enable_follows_action)
    else $error("compare output B enable does not follow action field");

  property p_nonpwm_set;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (!pwm && match_b_ev && act_b == 2'b11) |=> COMPARE_OUT_B;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set)
    else $error("set on match did not raise output B");

  property p_fast_top;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (fast && at_top && act_b == 2'b10) |=> COMPARE_OUT_B;
  endproperty
  a_fast_top: assert property (p_fast_top)
    else $error("fast mode did not set output B at top");

  property p_phase_down;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (phase && match_b_ev && down_r && act_b == 2'b10 && cmp_b_eff != top) |=> COMPARE_OUT_B;
  endproperty
  a_phase_down: assert property (p_phase_down)
    else $error("down-count match did not set output B");

  property p_ctrl_reserved;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (req && !WB_WE_I && !ack_r && WB_ADR_I == `OFS_WAVEFORM_CONTROL_B) |=>
        (WB_ACK_O && WB_DAT_O[7:4] == 4'h0);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("control B read returned nonzero reserved or force bits");

  property p_overflow_max;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (mode == MODE_NORMAL && tick && count_r == 8'hff) |=> flags_r[`BIT_FLAG_OVF];
  endproperty
  a_overflow_max: assert property (p_overflow_max)
    else $error("overflow flag missing at max");

  property p_force_no_flag;
    @(posedge CLK_SYS) disable iff (!RESET_N) $rose(flags_r[`BIT_FLAG_A]) |-> $past(match_a_ev);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag)
    else $error("flag A rose without a compare match");

  property p_stopped;
    @(posedge CLK_SYS) disable iff (!RESET_N) (cs == 3'h0 && !wr_count) |=> $stable(count_r);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_write_blocks;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (wr_count && cs == 3'h1) |=> (!match_a_ev && !match_b_ev);
  endproperty
  a_write_blocks: assert property (p_write_blocks)
    else $error("match not blocked after counter write");

  property p_ctc_restart;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (mode == MODE_CTC && tick && count_r == cmp_a_r && !wr_count) |=> count_r == 8'h00;
  endproperty
  a_ctc_restart: assert property (p_ctc_restart)
    else $error("clear-on-match did not restart the count");

endmodule
`default_nettype wire

// ==== core/timer2_regs.svh ====
// Register map, field positions, reset values and prescaler counts of the timer block.
// Assumes a 32-bit Wishbone slave with byte addresses; data sits in byte lane 0.
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH

`define OFS_WAVEFORM_CONTROL_A 8'h00
`define OFS_WAVEFORM_CONTROL_B 8'h04
`define OFS_COUNT_VALUE 8'h08
`define OFS_COMPARE_VALUE_A 8'h0c
`define OFS_COMPARE_VALUE_B 8'h10
`define OFS_FLAGS 8'h14

`define CTRL_A_RW_MASK 8'hf3
`define CTRL_B_RW_MASK 8'h0f
`define FLAGS_MASK 8'h07
`define BIT_FORCE_A 7
`define BIT_FORCE_B 6
`define BIT_MODE_HIGH 3
`define BIT_FLAG_OVF 0
`define BIT_FLAG_A 1
`define BIT_FLAG_B 2

`define RESET_BYTE 8'h00
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00

`define PRE_MASK_8 10'h007
`define PRE_MASK_32 10'h01f
`define PRE_MASK_64 10'h03f
`define PRE_MASK_128 10'h07f
`define PRE_MASK_256 10'h0ff
`define PRE_MASK_1024 10'h3ff

`endif

// ==== core/timer2_pkg.sv ====
// Types shared by the timer block.
// Assumes nothing beyond a SystemVerilog compiler.
package timer2_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PHASE_FF = 3'h1,
    MODE_CTC = 3'h2,
    MODE_FAST_FF = 3'h3,
    MODE_RSVD4 = 3'h4,
    MODE_PHASE_OCR = 3'h5,
    MODE_RSVD6 = 3'h6,
    MODE_FAST_OCR = 3'h7
  } wave_mode_t;
  typedef logic [1:0] out_action_t;
endpackage

// ==== bench/port_pin_model.sv ====
// Pad model for a pin shared by a compare output and port logic.
// Assumes an undriven pad is pulled high.
`timescale 1ns/1ns
`default_nettype none
module port_pin_model (
  // Port logic
  input wire logic dir,
  input wire logic port_dat,
  // Compare output
  input wire logic cmp_out,
  input wire logic cmp_en,
  // Pad
  output logic pad
);
  // The timer takes the pin, but software still owns the driver.
  assign pad = !dir ? 1'b1 : (cmp_en ? cmp_out : port_dat);
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the timer block and its compare B pad.
// Assumes the design answers every Wishbone request with one ack.
`timescale 1ns/1ns
`default_nettype none
`include "timer2_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
  typedef struct packed {logic chk; logic [7:0] v;} note_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic vd_a = 1'b0;
  logic vd_ovf = 1'b0;
  logic vd_b = 1'b0;
  logic dir_b = 1'b0;
  logic [31:0] rdat;
  logic ack, oa, oa_en, ob, ob_en, pad_b;
  logic [7:0] q;
  int error_cnt = 0;
  int total_checks = 0;
  int h;
  int g;
  int dv[6] = '{8, 32, 64, 128, 256, 1024};
  logic [1:0] code[4] = '{2'b01, 2'b10, 2'b11, 2'b01};
  logic e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  note_t exp_q[$];
  timer2_core timer2_core_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .VECTOR_DONE_A(vd_a), .VECTOR_DONE_B(vd_b),
    .VECTOR_DONE_OVF(vd_ovf), .COMPARE_OUT_A(oa), .COMPARE_OUT_A_EN(oa_en),
    .COMPARE_OUT_B(ob), .COMPARE_OUT_B_EN(ob_en));
  port_pin_model port_pin_model_i (.dir(dir_b), .port_dat(1'b0), .cmp_out(ob),
    .cmp_en(ob_en), .pad(pad_b));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("[FAIL] %0t no ack", $time);
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic c, input logic [7:0] v);
    exp_q.push_back({c, v});
    wb(1'b0, a, 8'h00);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic duty(input int n);
    h = 0;
    g = 0;
    repeat (n) begin
      @(posedge clk_sys);
      h += (ob === 1'b1);
      g += (oa === 1'b1);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Read results are judged here, against the oldest note of the driver.
  always @(posedge clk_sys) begin
    note_t n;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      if (n.chk) `CHK(rdat[7:0], n.v)
    end
  end
  initial begin
    waitc(30000);
    error_cnt++;
    $display("[FAIL] %0t timeout", $time);
    print_verdict();
  end
  initial begin
    void'($urandom(37186));
    waitc(4);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 1'b1, 8'h00);
    wr(`OFS_WAVEFORM_CONTROL_A, 8'hff);
    rd(`OFS_WAVEFORM_CONTROL_A, 1'b1, 8'hf3);
    wr(`OFS_WAVEFORM_CONTROL_B, 8'h38);
    rd(`OFS_WAVEFORM_CONTROL_B, 1'b1, 8'h08);
    wr(8'h18, 8'h55);
    rd(8'h18, 1'b1, 8'h00);
    for (int i = 2; i < 5; i++) begin
      h = $urandom;
      wr(8'(i * 4), 8'(h));
      rd(8'(i * 4), 1'b1, 8'(h));
    end
    wr(`OFS_WAVEFORM_CONTROL_B, 8'h00);
    wr(`OFS_WAVEFORM_CONTROL_A, 8'h00);
    $display("register test done");
    dir_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_WAVEFORM_CONTROL_A, {2'b01, code[i], 4'h0});
      wr(`OFS_WAVEFORM_CONTROL_B, 8'h40);
      waitc(2);
      `CHK(ob, e[i])
      `CHK(pad_b, e[i])
    end
    `CHK(oa_en, 1'b1)
    wr(`OFS_WAVEFORM_CONTROL_A, 8'h42);
    wr(`OFS_COMPARE_VALUE_A, 8'h10);
    wr(`OFS_COUNT_VALUE, 8'h10);
    wr(`OFS_WAVEFORM_CONTROL_B, 8'h80);
    waitc(2);
    `CHK(oa, 1'b1)
    rd(`OFS_COUNT_VALUE, 1'b1, 8'h10);
    rd(`OFS_WAVEFORM_CONTROL_B, 1'b1, 8'h00);
    rd(`OFS_FLAGS, 1'b1, 8'h00);
    $display("force test done");
    wr(`OFS_WAVEFORM_CONTROL_A, 8'h10);
    wr(`OFS_COMPARE_VALUE_B, 8'h40);
    wr(`OFS_COUNT_VALUE, 8'h11);
    wr(`OFS_WAVEFORM_CONTROL_B, 8'h01);
    wr(`OFS_COUNT_VALUE, 8'h40);
    waitc(20);
    `CHK(ob, 1'b0)
    rd(`OFS_FLAGS, 1'b1, 8'h00);
    waitc(280);
    `CHK(ob, 1'b1)
    rd(`OFS_FLAGS, 1'b1, 8'h07);
    wr(`OFS_FLAGS, 8'h02);
    vd_ovf <= 1'b1;
    @(posedge clk_sys);
    vd_ovf <= 1'b0;
    rd(`OFS_FLAGS, 1'b1, 8'h04);
    vd_a <= 1'b1;
    @(posedge clk_sys);
    vd_a <= 1'b0;
    rd(`OFS_FLAGS, 1'b1, 8'h04);
    vd_b <= 1'b1;
    @(posedge clk_sys);
    vd_b <= 1'b0;
    rd(`OFS_FLAGS, 1'b1, 8'h00);
    $display("normal mode test done");
    wr(`OFS_WAVEFORM_CONTROL_A, 8'h23);
    wr(`OFS_FLAGS, 8'h07);
    waitc(300);
    duty(512);
    `CHK(h inside {[127:133]}, 1'b1)
    rd(`OFS_FLAGS, 1'b1, 8'h07);
    wr(`OFS_WAVEFORM_CONTROL_A, 8'h21);
    waitc(600);
    duty(510);
    `CHK(h inside {[125:131]}, 1'b1)
    $display("pwm test done");
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_WAVEFORM_CONTROL_B, 8'h00);
      wr(`OFS_COUNT_VALUE, 8'h00);
      wr(`OFS_WAVEFORM_CONTROL_B, 8'(i + 2));
      waitc(dv[i] * 4);
      wr(`OFS_WAVEFORM_CONTROL_B, 8'h00);
      rd(`OFS_COUNT_VALUE, 1'b0, 8'h00);
      `CHK(q inside {[3:5]}, 1'b1)
    end
    waitc(50);
    rd(`OFS_COUNT_VALUE, 1'b1, q);
    $display("prescaler test done");
    wr(`OFS_WAVEFORM_CONTROL_A, 8'h02);
    wr(`OFS_COMPARE_VALUE_A, 8'h09);
    wr(`OFS_FLAGS, 8'h07);
    wr(`OFS_WAVEFORM_CONTROL_B, 8'h01);
    for (int i = 0; i < 4; i++) begin
      waitc($urandom_range(20, 0));
      rd(`OFS_COUNT_VALUE, 1'b0, 8'h00);
      `CHK(q <= 8'h09, 1'b1)
    end
    rd(`OFS_FLAGS, 1'b1, 8'h02);
    $display("clear on match test done");
    // Compare B equal to top in mode 5 must hold output B high for good.
    wr(`OFS_COMPARE_VALUE_B, 8'h09);
    wr(`OFS_WAVEFORM_CONTROL_B, 8'h09);
    wr(`OFS_WAVEFORM_CONTROL_A, 8'h61);
    waitc(300);
    duty(360);
    `CHK(g inside {[178:182]}, 1'b1)
    `CHK(h, 360)
    $display("top compare test done");
    print_verdict();
  end
endmodule
`default_nettype wire
